// ===== design/ic_pkg.sv
// Constants, offsets and field layouts shared by the interrupt controller files
package ic_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Sizes
  localparam int unsigned NSRC = 32;         // Number of interrupt sources
  localparam int unsigned STACK_DEPTH = 8;   // Level stack entries, one per priority
  localparam int unsigned PRIO_W = 3;        // Priority field width
  localparam int unsigned KIND_W = 2;        // Trigger kind field width

  ////////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [11:0] SMR_BASE = 12'h000;   // Source mode table, 32 words
  localparam logic [11:0] SVR_BASE = 12'h080;   // Source vector table, 32 words
  localparam logic [11:0] IVR_OFS = 12'h100;    // Normal vector readout
  localparam logic [11:0] FVR_OFS = 12'h104;    // Fast vector readout
  localparam logic [11:0] ISR_OFS = 12'h108;    // Current source status
  localparam logic [11:0] IPR_OFS = 12'h10C;    // Pending bits
  localparam logic [11:0] IMR_OFS = 12'h110;    // Enable mask bits
  localparam logic [11:0] CISR_OFS = 12'h114;   // Core line status
  localparam logic [11:0] IECR_OFS = 12'h120;   // Enable command
  localparam logic [11:0] IDCR_OFS = 12'h124;   // Disable command
  localparam logic [11:0] ICCR_OFS = 12'h128;   // Clear pending command
  localparam logic [11:0] ISCR_OFS = 12'h12C;   // Set pending command
  localparam logic [11:0] EOICR_OFS = 12'h130;  // End of service command
  localparam logic [11:0] SPU_OFS = 12'h134;    // Unexpected handler address

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions and reset values
  localparam int unsigned PRIO_LSB = 0;        // urgency_level in mode word
  localparam int unsigned KIND_LSB = 5;        // trigger_kind in mode word
  localparam int unsigned CISR_FAST_BIT = 0;   // Fast line active
  localparam int unsigned CISR_NORMAL_BIT = 1; // Normal line active
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  // Sources whose polarity software may choose; the others are fixed active high
  localparam logic [31:0] EXTERNAL_SRC = 32'h0000_000F;

  // Trigger kinds: bit 1 selects edge, bit 0 selects negative polarity
  typedef enum logic [1:0] {
    KIND_POS_LEVEL = 2'h0,
    KIND_NEG_LEVEL = 2'h1,
    KIND_RISE_EDGE = 2'h2,
    KIND_FALL_EDGE = 2'h3
  } trigger_kind_t;

endpackage

// ===== design/src_cell.sv
// One interrupt source: polarity, edge detection and pending state
`timescale 1ns/1ns
module src_cell #(
  parameter bit INTERNAL = 1'b0  // Fixed active-high polarity when set
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic level,        // Synchronised request input
  input wire logic [1:0] kind,   // trigger_kind field
  input wire logic set_cmd,      // Software or test set
  input wire logic clr_cmd,      // Software clear or acknowledge
  output logic pending
);

  logic lvl;          // Request after polarity
  logic is_edge;      // Edge mode selected
  logic prev_q;       // Last polarity-adjusted level
  logic edge_q;       // Latched edge request

  // Internal sources ignore the polarity bit
  assign lvl = (kind[0] & ~INTERNAL) ? ~level : level;
  assign is_edge = kind[1];

  // Level history for edge detection
  always_ff @(posedge clk) begin
    if (rst) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= lvl;
    end
  end

  // Edge latch; a new edge or a set beats a clear in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      edge_q <= 1'b0;
    end else if (!is_edge) begin
      edge_q <= 1'b0;
    end else if ((lvl & ~prev_q) | set_cmd) begin
      edge_q <= 1'b1;
    end else if (clr_cmd) begin
      edge_q <= 1'b0;
    end
  end

  // Level sources follow the input live
  assign pending = is_edge ? edge_q : lvl;

endmodule // src_cell

// ===== design/prio_pick.sv
// Picks the highest-priority requesting source among 1 to 31
`timescale 1ns/1ns
module prio_pick (
  input wire logic [31:0] req,        // Pending and enabled, bit 0 ignored
  input wire logic [95:0] prio_flat,  // Three bits per source
  output logic found,
  output logic [4:0] src,
  output logic [2:0] level
);

  // Scan downward so that on a tie the lower number is taken last
  always_comb begin
    found = 1'b0;
    src = 5'h00;
    level = 3'h0;
    for (int i = 31; i >= 1; i--) begin
      if (req[i] && (!found || prio_flat[i*3 +: 3] >= level)) begin
        found = 1'b1;
        src = 5'(i);
        level = prio_flat[i*3 +: 3];
      end
    end
  end

endmodule // prio_pick

// ===== design/vectored_interrupt_controller.sv
// Vectored, prioritised interrupt controller for 32 sources with APB registers
//
// Behaviour
// - Vector read makes best pending source current
// - Vector read drops the normal request line
// - Vector read clears edge source that became current
// - Vector read pushes the new level on stack
// - Vector read returns current source's vector
// - Vector reads zero with no current interrupt
// - End-of-service write pops the level stack
// - After pop, request again if pending above new
// - Higher pending source reasserts request while nested
// - Fast vector read returns vector zero, clears edge
// - Priority 0 to 7, ignored for source 0
// - Mode selects level or edge, and polarity for sources 0 to 3
// - Mode table then vector table, consecutive words
// - Status register shows current source number
// - Pending register shows one bit per source
// - Enable and disable commands set, clear mask
// - Mask register reads one bit per source
// - Clear and set commands change pending state; sources in level mode ignore them
// - Core status shows both request lines live
// - Equal priority: lowest source number wins
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ns
module vectored_interrupt_controller (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [31:0] irq_in,          // Source request inputs
  output logic normal_request_line_n,      // Normal request to core, active low
  output logic fast_request_line_n         // Fast request to core, active low
);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [31:0] meta_q;                     // First synchroniser stage
  logic [31:0] sync_q;                     // Second synchroniser stage
  logic [2:0] prio_q [32];                 // urgency_level per source
  logic [1:0] kind_q [32];                 // trigger_kind per source
  logic [31:0] vec_q [32];                 // Handler address per source
  logic [31:0] spu_q;                      // unexpected_handler_addr
  logic [31:0] mask_q;                     // Enable mask
  logic [4:0] stk_src_q [8];               // Stacked source numbers
  logic [2:0] stk_pri_q [8];               // Stacked levels
  logic [3:0] depth_q;                     // Stack fill, 0 to 8
  logic ready_q;                           // Access phase wait done
  logic [31:0] prdata_q;                   // Captured read data
  logic normal_n_q;                        // Normal line flop
  logic fast_n_q;                          // Fast line flop
  logic [31:0] pend;                       // Pending per source
  logic [31:0] set_v;                      // Set strobes to cells
  logic [31:0] clr_v;                      // Clear strobes to cells
  logic [95:0] prio_flat;                  // Priorities to resolver
  logic found;                             // Some source eligible
  logic [4:0] best_src;                    // Best eligible source
  logic [2:0] best_pri;                    // Its priority
  logic [2:0] top;                         // Stack top index
  logic [4:0] cur_src;                     // current_source_number
  logic [2:0] cur_pri;                     // Current level
  logic have_cur;                          // A current interrupt exists
  logic irq_act;                           // Normal request wanted
  logic fiq_act;                           // Fast request wanted
  logic access;                            // APB access phase
  logic cap;                               // Read capture edge
  logic wr;                                // Write commit edge
  logic [11:0] off;                        // Word-aligned offset
  logic [4:0] idx;                         // Table index
  logic is_smr;                            // Mode table hit
  logic is_svr;                            // Vector table hit
  logic ivr_rd;                            // Normal vector read
  logic fvr_rd;                            // Fast vector read
  logic push;                              // Acknowledge takes new source
  logic pop;                               // End of service with stack
  logic hit;                               // Address is mapped
  logic [31:0] rdata;                      // Read mux
  logic beaten;                            // An eligible source outranks the pick

  ////////////////////////////////////////////////////////////////////////////////
  // Request input synchroniser
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= ic_pkg::WORD_RESET;
      sync_q <= ic_pkg::WORD_RESET;
    end else begin
      meta_q <= irq_in;
      sync_q <= meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // APB decode; every access takes one wait state
  assign access = psel & penable;
  assign cap = access & ~ready_q & ~pwrite;
  assign wr = access & ready_q & pwrite;
  assign off = {paddr[11:2], 2'h0};
  assign idx = paddr[6:2];
  assign is_smr = off < ic_pkg::SVR_BASE;
  assign is_svr = (off >= ic_pkg::SVR_BASE) && (off < ic_pkg::IVR_OFS);
  assign pready = ready_q;
  assign pslverr = ready_q & ~hit;
  assign prdata = prdata_q;

  // Wait-state flop: high in the second access cycle only
  always_ff @(posedge clk) begin
    if (rst) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= access & ~ready_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Current interrupt and acknowledge
  assign top = 3'(depth_q - 4'h1);
  assign have_cur = depth_q != 4'h0;
  assign cur_src = have_cur ? stk_src_q[top] : 5'h00;
  assign cur_pri = stk_pri_q[top];
  assign ivr_rd = cap && (off == ic_pkg::IVR_OFS);
  assign fvr_rd = cap && (off == ic_pkg::FVR_OFS);
  // Request when the best source outranks the current level
  assign irq_act = found && (!have_cur || best_pri > cur_pri);
  assign push = ivr_rd & irq_act;
  assign pop = wr && (off == ic_pkg::EOICR_OFS) && have_cur;
  assign fiq_act = pend[0] & mask_q[0];

  ////////////////////////////////////////////////////////////////////////////////
  // Per-source cells and resolver
  always_comb begin
    set_v = 32'h0000_0000;
    clr_v = 32'h0000_0000;
    if (wr && off == ic_pkg::ISCR_OFS) begin
      set_v = pwdata;
    end
    if (wr && off == ic_pkg::ICCR_OFS) begin
      clr_v = pwdata;
    end
    // Acknowledge clears the taken source; cells ignore it in level mode
    if (push) begin
      clr_v = clr_v | (32'h0000_0001 << best_src);
    end
    if (fvr_rd) begin
      clr_v[0] = 1'b1;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 32; g++) begin : g_src
      src_cell #(
        .INTERNAL(!ic_pkg::EXTERNAL_SRC[g])
      ) u_cell (
        .clk(clk),
        .rst(rst),
        .level(sync_q[g]),
        .kind(kind_q[g]),
        .set_cmd(set_v[g]),
        .clr_cmd(clr_v[g]),
        .pending(pend[g])
      );
      assign prio_flat[g*3 +: 3] = prio_q[g];
    end
  endgenerate

  // Source 0 never competes on the normal line
  prio_pick u_pick (
    .req(pend & mask_q & 32'hFFFF_FFFE),
    .prio_flat(prio_flat),
    .found(found),
    .src(best_src),
    .level(best_pri)
  );

  // Second scan for the resolver check: set when some eligible source should have won
  always_comb begin
    beaten = 1'b0;
    for (int i = 1; i < 32; i++) begin
      if (pend[i] && mask_q[i]) begin
        // Higher priority, or equal priority with a lower number
        if (prio_q[i] > best_pri || (prio_q[i] == best_pri && 5'(i) < best_src)) begin
          beaten = 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Level stack
  always_ff @(posedge clk) begin
    if (rst) begin
      depth_q <= 4'h0;
    end else if (push && depth_q < 4'(ic_pkg::STACK_DEPTH)) begin
      stk_src_q[depth_q[2:0]] <= best_src;
      stk_pri_q[depth_q[2:0]] <= best_pri;
      depth_q <= depth_q + 4'h1;
    end else if (pop) begin
      depth_q <= depth_q - 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Request lines to the core
  always_ff @(posedge clk) begin
    if (rst) begin
      normal_n_q <= 1'b1;
      fast_n_q <= 1'b1;
    end else begin
      // Acknowledge forces the line off in the same edge
      normal_n_q <= ~(irq_act & ~push);
      // Only an edge-mode fast read drops the fast line; level waits for source
      fast_n_q <= ~(fiq_act & ~(fvr_rd & kind_q[0][1]));
    end
  end
  assign normal_request_line_n = normal_n_q;
  assign fast_request_line_n = fast_n_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < 32; i++) begin
        prio_q[i] <= 3'h0;
        kind_q[i] <= 2'h0;
        vec_q[i] <= ic_pkg::WORD_RESET;
      end
      spu_q <= ic_pkg::WORD_RESET;
    end else if (wr) begin
      if (is_smr) begin
        prio_q[idx] <= pwdata[ic_pkg::PRIO_LSB +: ic_pkg::PRIO_W];
        kind_q[idx] <= pwdata[ic_pkg::KIND_LSB +: ic_pkg::KIND_W];
      end
      if (is_svr) begin
        vec_q[idx] <= pwdata;
      end
      if (off == ic_pkg::SPU_OFS) begin
        spu_q <= pwdata;
      end
    end
  end

  // Enable mask commands
  always_ff @(posedge clk) begin
    if (rst) begin
      mask_q <= ic_pkg::WORD_RESET;
    end else if (wr && off == ic_pkg::IECR_OFS) begin
      mask_q <= mask_q | pwdata;
    end else if (wr && off == ic_pkg::IDCR_OFS) begin
      mask_q <= mask_q & ~pwdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read mux and address map
  always_comb begin
    rdata = 32'h0000_0000;
    hit = 1'b1;
    if (is_smr) begin
      rdata[ic_pkg::PRIO_LSB +: ic_pkg::PRIO_W] = prio_q[idx];
      rdata[ic_pkg::KIND_LSB +: ic_pkg::KIND_W] = kind_q[idx];
    end else if (is_svr) begin
      rdata = vec_q[idx];
    end else begin
      case (off)
        ic_pkg::IVR_OFS: begin
          // Newly taken source, else the one in service, else zero
          if (push) begin
            rdata = vec_q[best_src];
          end else if (have_cur) begin
            rdata = vec_q[cur_src];
          end else begin
            rdata = 32'h0000_0000;
          end
        end
        ic_pkg::FVR_OFS: rdata = vec_q[0];
        ic_pkg::ISR_OFS: rdata = {27'h0, cur_src};
        ic_pkg::IPR_OFS: rdata = pend;
        ic_pkg::IMR_OFS: rdata = mask_q;
        ic_pkg::CISR_OFS: begin
          rdata[ic_pkg::CISR_FAST_BIT] = ~fast_n_q;
          rdata[ic_pkg::CISR_NORMAL_BIT] = ~normal_n_q;
        end
        ic_pkg::SPU_OFS: rdata = spu_q;
        ic_pkg::IECR_OFS, ic_pkg::IDCR_OFS, ic_pkg::ICCR_OFS: rdata = 32'h0000_0000;
        ic_pkg::ISCR_OFS, ic_pkg::EOICR_OFS: rdata = 32'h0000_0000;
        default: hit = 1'b0;
      endcase
    end
  end

  // Read data is captured in the first access cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      prdata_q <= ic_pkg::WORD_RESET;
    end else if (cap) begin
      prdata_q <= rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions
  a_ack_drops_line: assert property (@(posedge clk) disable iff (rst)
    push |=> normal_n_q) else $error("normal line not dropped by vector read");

  a_push_grows_stack: assert property (@(posedge clk) disable iff (rst)
    push |=> depth_q == $past(depth_q) + 4'h1) else $error("stack did not grow");

  a_push_sets_level: assert property (@(posedge clk) disable iff (rst)
    push |=> cur_pri == $past(best_pri) && cur_src == $past(best_src))
    else $error("current level not taken from best source");

  a_pop_shrinks: assert property (@(posedge clk) disable iff (rst)
    pop |=> depth_q == $past(depth_q) - 4'h1) else $error("stack did not pop");

  // A source above the level in service must pull the line low next cycle
  a_nest_raises: assert property (@(posedge clk) disable iff (rst)
    (have_cur && found && best_pri > cur_pri && !ivr_rd) |=> !normal_n_q)
    else $error("higher source not requested");

  a_idle_vector_zero: assert property (@(posedge clk) disable iff (rst)
    (ivr_rd && !have_cur && !found) |=> prdata_q == 32'h0000_0000)
    else $error("vector not zero with no current interrupt");

  // A set command or a fresh edge in the read cycle may keep source 0 pending
  a_fast_edge_clear: assert property (@(posedge clk) disable iff (rst)
    (fvr_rd && kind_q[0][1]) |=> fast_n_q && (!pend[0] || $past(set_v[0])
    || ($past(sync_q[0]) != $past(sync_q[0], 2))))
    else $error("fast edge read did not clear");

  a_mask_enable: assert property (@(posedge clk) disable iff (rst)
    (wr && off == ic_pkg::IECR_OFS) |=> (mask_q & $past(pwdata)) == $past(pwdata))
    else $error("enable command did not set mask");

  a_stack_bound: assert property (@(posedge clk) disable iff (rst)
    depth_q <= 4'h8) else $error("stack overflow");

  a_tie_lowest: assert property (@(posedge clk) disable iff (rst)
    push |-> !beaten) else $error("resolver did not take the best source");

endmodule // vectored_interrupt_controller

// ===== tb/core_model.sv
// Behavioural processor core that counts the interrupt requests it takes
`timescale 1ns/1ns
module core_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic normal_request_line_n,
  input wire logic fast_request_line_n,
  input wire logic irq_masked,     // Status word bit that masks normal requests
  output logic [7:0] taken,        // Normal requests entered so far
  output logic [7:0] fast_taken    // Fast requests entered so far
);
  logic line_q;  // Normal line one cycle ago
  logic fast_q;  // Fast line one cycle ago

  ////////////////////////////////////////////////////////////////////////////////
  // Enter a handler on a falling request line; a normal line that falls while masked is not counted
  always_ff @(posedge clk) begin
    line_q <= normal_request_line_n;
    fast_q <= fast_request_line_n;
    if (rst) begin
      taken <= 8'h00;
      fast_taken <= 8'h00;
    end else begin
      if (!irq_masked && line_q && !normal_request_line_n) begin
        taken <= taken + 8'h01;
      end
      if (fast_q && !fast_request_line_n) begin
        fast_taken <= fast_taken + 8'h01;
      end
    end
  end
endmodule  // core_model

// ===== tb/vectored_interrupt_controller_tb.sv
// Self-checking testbench for the vectored interrupt controller
`timescale 1ns/1ns
module vectored_interrupt_controller_tb;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, err, irq_masked;
  logic normal_request_line_n, fast_request_line_n;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, irq_in, rd;
  logic [7:0] taken, fast_taken;
  logic [11:0] zero_addr [12];  // Registers that read zero after reset
  int err_count = 0;
  int n_tests = 0;

  vectored_interrupt_controller vectored_interrupt_controller_i (.clk(clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_in(irq_in),
    .normal_request_line_n(normal_request_line_n), .fast_request_line_n(fast_request_line_n));
  core_model core_model_i (.clk(clk), .rst(rst), .normal_request_line_n(normal_request_line_n),
    .fast_request_line_n(fast_request_line_n), .irq_masked(irq_masked), .taken(taken),
    .fast_taken(fast_taken));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, 4 ns period
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Closing report and comparison helpers
  task automatic test_done();
    $display("Counts: %0d compares, %0d mismatches", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer, entered at a rising edge; holds until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // Values read here are those the slave shows at this rising edge
    while (pready !== 1'b1 && n < 16) begin
      @(posedge clk);
      n++;
    end
    if (n == 16) begin
      err_count++;
      test_done();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask

  // Waits, bounded, for a request line to reach a level, then realigns to a rising edge
  task automatic wait_line(input logic fast, input logic lvl);
    int n;
    n = 0;
    repeat (3) @(negedge clk);
    while ((fast ? fast_request_line_n : normal_request_line_n) !== lvl && n < 16) begin
      @(negedge clk);
      n++;
    end
    chk({31'h0, fast ? fast_request_line_n : normal_request_line_n}, {31'h0, lvl});
    if (n == 16) begin
      test_done();
    end
    @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    irq_in = 32'h0000_0000;
    irq_masked = 1'b1;
    zero_addr = '{ic_pkg::SMR_BASE, 12'h07C, ic_pkg::SVR_BASE, 12'h0FC, ic_pkg::IVR_OFS,
      ic_pkg::FVR_OFS, ic_pkg::ISR_OFS, ic_pkg::IPR_OFS, ic_pkg::IMR_OFS, ic_pkg::CISR_OFS,
      ic_pkg::SPU_OFS, ic_pkg::IECR_OFS};
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    // Reset values, lines idle, unmapped address refused
    chk({30'h0, normal_request_line_n, fast_request_line_n}, 32'h3);
    foreach (zero_addr[i]) begin
      rdchk(zero_addr[i], 32'h0000_0000);
    end
    apb(1'b1, 12'h118, 32'hFFFF_FFFF);
    chk({31'h0, err}, 32'h1);
    rdchk(12'h118, 32'h0000_0000);
    chk({31'h0, err}, 32'h1);
    $display("test reset_and_map done");
    // Vector table, unexpected vector, mode words
    for (int i = 0; i < 32; i++) begin
      apb(1'b1, ic_pkg::SVR_BASE + 12'(4 * i), 32'h0000_1000 + 32'(i));
    end
    for (int i = 0; i < 32; i++) begin
      rdchk(ic_pkg::SVR_BASE + 12'(4 * i), 32'h0000_1000 + 32'(i));
    end
    apb(1'b1, ic_pkg::SPU_OFS, 32'hCAFE_0134);
    rdchk(ic_pkg::SPU_OFS, 32'hCAFE_0134);
    apb(1'b1, 12'h014, 32'h0000_0042);
    apb(1'b1, 12'h018, 32'h0000_0042);
    apb(1'b1, 12'h024, 32'h0000_0047);
    apb(1'b1, ic_pkg::SMR_BASE, 32'h0000_0040);
    rdchk(12'h024, 32'h0000_0047);
    apb(1'b1, ic_pkg::IECR_OFS, 32'hF000_0261);
    apb(1'b1, ic_pkg::IDCR_OFS, 32'hF000_0000);
    rdchk(ic_pkg::IMR_OFS, 32'h0000_0261);
    $display("test tables done");
    // Equal priorities, nesting, stack pops
    irq_masked <= 1'b0;
    apb(1'b1, ic_pkg::ISCR_OFS, 32'h0000_0060);
    rdchk(ic_pkg::IPR_OFS, 32'h0000_0060);
    wait_line(1'b0, 1'b0);
    rdchk(ic_pkg::CISR_OFS, 32'h0000_0002);
    rdchk(ic_pkg::IVR_OFS, 32'h0000_1005);
    wait_line(1'b0, 1'b1);
    rdchk(ic_pkg::ISR_OFS, 32'h0000_0005);
    rdchk(ic_pkg::IPR_OFS, 32'h0000_0040);
    apb(1'b1, ic_pkg::ISCR_OFS, 32'h0000_0200);
    wait_line(1'b0, 1'b0);
    rdchk(ic_pkg::IVR_OFS, 32'h0000_1009);
    rdchk(ic_pkg::ISR_OFS, 32'h0000_0009);
    irq_masked <= 1'b1;
    apb(1'b1, ic_pkg::EOICR_OFS, 32'hDEAD_BEEF);
    wait_line(1'b0, 1'b1);
    apb(1'b1, ic_pkg::EOICR_OFS, 32'h0000_0000);
    wait_line(1'b0, 1'b0);
    rdchk(ic_pkg::IVR_OFS, 32'h0000_1006);
    apb(1'b1, ic_pkg::EOICR_OFS, 32'h0000_0001);
    rdchk(ic_pkg::IVR_OFS, 32'h0000_0000);
    chk({24'h0, taken}, 32'h2);
    $display("test nesting done");
    // Fast source, edge then level
    apb(1'b1, ic_pkg::ISCR_OFS, 32'h0000_0001);
    wait_line(1'b1, 1'b0);
    rdchk(ic_pkg::CISR_OFS, 32'h0000_0001);
    rdchk(ic_pkg::FVR_OFS, 32'h0000_1000);
    wait_line(1'b1, 1'b1);
    apb(1'b1, ic_pkg::SMR_BASE, 32'h0000_0000);
    irq_in[0] <= 1'b1;
    wait_line(1'b1, 1'b0);
    rdchk(ic_pkg::FVR_OFS, 32'h0000_1000);
    wait_line(1'b1, 1'b0);
    irq_in[0] <= 1'b0;
    wait_line(1'b1, 1'b1);
    chk({24'h0, fast_taken}, 32'h2);
    $display("test fast done");
    // Every trigger kind on one external source
    for (int k = 0; k < 4; k++) begin
      irq_in[2] <= k[0];
      @(posedge clk);
      apb(1'b1, 12'h008, {25'h0, k[1:0], 5'h00});
      apb(1'b1, ic_pkg::ICCR_OFS, 32'h0000_0004);
      irq_in[2] <= ~k[0];
      repeat (4) @(posedge clk);
      rdchk(ic_pkg::IPR_OFS, 32'h0000_0004);
      irq_in[2] <= k[0];
      repeat (4) @(posedge clk);
      rdchk(ic_pkg::IPR_OFS, k[1] ? 32'h0000_0004 : 32'h0000_0000);
    end
    apb(1'b1, ic_pkg::ICCR_OFS, 32'h0000_0004);
    rdchk(ic_pkg::IPR_OFS, 32'h0000_0000);
    $display("test trigger_kinds done");
    test_done();
  end
endmodule  // vectored_interrupt_controller_tb
